/* File: verilog/rhs_root_hub_status.sv */
/*
 * rhs_root_hub_status: root hub global status register with global overcurrent
 * tracking, global/masked port power commands, remote wake-up enable and
 * the per-port power exempt mask field of the second descriptor register.
 * Assumes commands are one-cycle requests synchronous to CLOCK and that the
 * overcurrent, attach-change and suspend inputs are synchronous as well.
 */
// How it works
// - low half holds hub status, high half the overcurrent change bit 17 and the bit 16 and bit 31 commands
// - code 14H reads and code 94H writes this same register
// - one in bit 31 clears wake-up enable; zero does nothing; write-only
// - overcurrent change flag bit 17 sets whenever overcurrent bit 1 changes
// - only a written one in bit 17 clears the overcurrent change flag
// - bits 0 and 16 always read as zero
// - global mode: one in bit 16 powers all ports on
// - per-port mode: one in bit 16 powers only unmasked ports on
// - wake enable lets attach change resume a suspended controller and interrupt
// - one in bit 15 sets wake-up enable; zero does nothing
// - global reporting: bit 1 follows the overcurrent condition
// - per-port overcurrent reporting forces bit 1 to read zero
// - global mode: one in bit 0 powers all ports off
// - per-port mode: one in bit 0 powers only unmasked ports off
// - every bit of the register is zero after reset
// - exempt mask sits in descriptor bits 18 to 16, exempting ports
`timescale 1ns/1ps
`default_nettype none
module rhs_root_hub_status #(
    parameter int NUM_PORTS = 2
) (
    input  wire logic                 CLOCK,          // 125 MHz core clock
    input  wire logic                 RST_N,          // async reset, active low
    input  wire rhs_pkg::rhs_cmd_t    CMD,            // one-cycle command from host bus
    output logic [31:0]               RD_DATA,        // read data, registered
    output logic                      RD_VALID,       // read data strobe, one cycle
    input  wire logic                 OC_IN,          // global overcurrent condition level
    input  wire logic                 PER_PORT_OC,    // overcurrent reported per port
    input  wire logic                 PER_PORT_SWITCH,// power switching mode, 1 = per port
    input  wire logic [NUM_PORTS:1]   ATTACH_CHANGE,  // per-port attach change pulses
    input  wire logic                 SUSPENDED,      // controller is in suspended state
    output logic [NUM_PORTS:1]        PORT_POWERED,   // port power status flags
    output logic                      RESUME_REQ,     // suspended to resuming, one-cycle pulse
    output logic                      RESUME_IRQ      // resume seen interrupt, one-cycle pulse
);
    // the mask field has one reserved bit, so at most two ports fit
    if (NUM_PORTS < 1 || NUM_PORTS > rhs_pkg::MASK_FIELD_W - 1)
    begin : g_bad_ports
        $error("NUM_PORTS must fit the exempt mask field");
    end

    logic                 oc_flag_reg;
    logic                 oc_change_reg;
    logic                 wake_en_reg;
    logic [NUM_PORTS:1]   exempt_mask_reg;
    logic [NUM_PORTS:1]   powered_reg;
    logic                 oc_flag_next;
    logic                 st_wr;
    logic                 st_rd;
    logic                 db_wr;
    logic                 db_rd;
    logic [NUM_PORTS:1]   target;
    logic [31:0]          status_word;
    logic [31:0]          descb_word;

    assign st_wr = CMD.valid && CMD.code == rhs_pkg::CMD_STATUS_WR;
    assign st_rd = CMD.valid && CMD.code == rhs_pkg::CMD_STATUS_RD;
    assign db_wr = CMD.valid && CMD.code == rhs_pkg::CMD_DESCB_WR;
    assign db_rd = CMD.valid && CMD.code == rhs_pkg::CMD_DESCB_RD;

    // per-port reporting leaves the global indicator idle
    assign oc_flag_next = OC_IN && !PER_PORT_OC;

    // ports touched by a global power command
    assign target = PER_PORT_SWITCH ? ~exempt_mask_reg : {NUM_PORTS{1'b1}};

    always_comb
    begin
        status_word = rhs_pkg::STATUS_RESET;
        status_word[rhs_pkg::BIT_OC_FLAG] = oc_flag_reg;
        status_word[rhs_pkg::BIT_WAKE_EN] = wake_en_reg;
        status_word[rhs_pkg::BIT_OC_CHANGE] = oc_change_reg;
        // bits 0, 16 and 31 stay zero on read
        status_word[rhs_pkg::BIT_POWER_OFF] = 1'b0;
        status_word[rhs_pkg::BIT_POWER_ON] = 1'b0;
    end

    always_comb
    begin
        descb_word = 32'h0000_0000;
        descb_word[rhs_pkg::MASK_LSB + NUM_PORTS -: NUM_PORTS] = exempt_mask_reg;
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
            oc_flag_reg <= rhs_pkg::FLAG_RESET;
        else
            oc_flag_reg <= oc_flag_next;
    end

    // a change in the same cycle as a clear wins
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
            oc_change_reg <= rhs_pkg::FLAG_RESET;
        else if (oc_flag_next != oc_flag_reg)
            oc_change_reg <= 1'b1;
        else if (st_wr && CMD.data[rhs_pkg::BIT_OC_CHANGE])
            oc_change_reg <= 1'b0;
    end

    // set and clear in one write: clear is taken, the safer state for wake-up
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
            wake_en_reg <= rhs_pkg::FLAG_RESET;
        else if (st_wr && CMD.data[rhs_pkg::BIT_WAKE_CLR])
            wake_en_reg <= 1'b0;
        else if (st_wr && CMD.data[rhs_pkg::BIT_WAKE_EN])
            wake_en_reg <= 1'b1;
    end

    // bit 16 of the mask field has no port behind it
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
            exempt_mask_reg <= '0;
        else if (db_wr)
            exempt_mask_reg <= CMD.data[rhs_pkg::MASK_LSB + NUM_PORTS -: NUM_PORTS];
    end

    // power on beats power off when both are written together
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
            powered_reg <= '0;
        else if (st_wr && CMD.data[rhs_pkg::BIT_POWER_ON])
            powered_reg <= powered_reg | target;
        else if (st_wr && CMD.data[rhs_pkg::BIT_POWER_OFF])
            powered_reg <= powered_reg & ~target;
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            RESUME_REQ <= 1'b0;
            RESUME_IRQ <= 1'b0;
        end
        else
        begin
            RESUME_REQ <= wake_en_reg && SUSPENDED && |ATTACH_CHANGE;
            RESUME_IRQ <= wake_en_reg && SUSPENDED && |ATTACH_CHANGE;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            RD_DATA  <= 32'h0000_0000;
            RD_VALID <= 1'b0;
        end
        else
        begin
            RD_VALID <= st_rd || db_rd;
            if (st_rd)
                RD_DATA <= status_word;
            else if (db_rd)
                RD_DATA <= descb_word;
        end
    end

    assign PORT_POWERED = powered_reg;

    property p_oc_change_sets;
        @(posedge CLOCK) disable iff (!RST_N)
        (oc_flag_next != oc_flag_reg) |=> oc_change_reg;
    endproperty
    a_oc_change_sets: assert property (p_oc_change_sets) else $error("change flag missed");

    property p_oc_change_clear;
        @(posedge CLOCK) disable iff (!RST_N)
        $fell(oc_change_reg) |-> $past(st_wr) && $past(CMD.data[rhs_pkg::BIT_OC_CHANGE]);
    endproperty
    a_oc_change_clear: assert property (p_oc_change_clear) else $error("change flag lost");

    property p_oc_masked;
        @(posedge CLOCK) disable iff (!RST_N)
        PER_PORT_OC ##1 PER_PORT_OC |-> !oc_flag_reg;
    endproperty
    a_oc_masked: assert property (p_oc_masked) else $error("indicator set in per-port mode");

    property p_read_zero_bits;
        @(posedge CLOCK) disable iff (!RST_N)
        st_rd |=> RD_VALID && !RD_DATA[0] && !RD_DATA[16] && !RD_DATA[31];
    endproperty
    a_read_zero_bits: assert property (p_read_zero_bits) else $error("fixed bit read nonzero");

    property p_read_status;
        @(posedge CLOCK) disable iff (!RST_N)
        st_rd |=> RD_DATA[rhs_pkg::BIT_OC_CHANGE] == $past(oc_change_reg)
              && RD_DATA[rhs_pkg::BIT_WAKE_EN] == $past(wake_en_reg);
    endproperty
    a_read_status: assert property (p_read_status) else $error("status read wrong");

    property p_wake_clear;
        @(posedge CLOCK) disable iff (!RST_N)
        st_wr && CMD.data[rhs_pkg::BIT_WAKE_CLR] |=> !wake_en_reg;
    endproperty
    a_wake_clear: assert property (p_wake_clear) else $error("wake enable not cleared");

    property p_wake_set;
        @(posedge CLOCK) disable iff (!RST_N)
        st_wr && CMD.data[rhs_pkg::BIT_WAKE_EN] && !CMD.data[rhs_pkg::BIT_WAKE_CLR]
            |=> wake_en_reg;
    endproperty
    a_wake_set: assert property (p_wake_set) else $error("wake enable not set");

    property p_power_on;
        @(posedge CLOCK) disable iff (!RST_N)
        st_wr && CMD.data[rhs_pkg::BIT_POWER_ON] |=> (PORT_POWERED & $past(target)) == $past(target)
            && (PORT_POWERED & ~$past(target)) == ($past(powered_reg) & ~$past(target));
    endproperty
    a_power_on: assert property (p_power_on) else $error("power on wrong ports");

    property p_power_off;
        @(posedge CLOCK) disable iff (!RST_N)
        st_wr && CMD.data[rhs_pkg::BIT_POWER_OFF] && !CMD.data[rhs_pkg::BIT_POWER_ON]
            |=> (PORT_POWERED & $past(target)) == '0
            && (PORT_POWERED & ~$past(target)) == ($past(powered_reg) & ~$past(target));
    endproperty
    a_power_off: assert property (p_power_off) else $error("power off wrong ports");

    property p_resume;
        @(posedge CLOCK) disable iff (!RST_N)
        RESUME_IRQ |-> $past(wake_en_reg) && $past(SUSPENDED) && $past(|ATTACH_CHANGE)
            && RESUME_REQ;
    endproperty
    a_resume: assert property (p_resume) else $error("resume without cause");
endmodule
`default_nettype wire

/* File: verilog/rhs_pkg.sv */
/*
 * rhs_pkg: command codes, bit positions, reset values and the command carrier
 * of the root hub global status and power control block.
 * Assumes the host bus front end turns processor cycles into one-cycle commands.
 */
`default_nettype none
package rhs_pkg;
    localparam logic [7:0]  CMD_STATUS_RD   = 8'h14;
    localparam logic [7:0]  CMD_STATUS_WR   = 8'h94;
    localparam logic [7:0]  CMD_DESCB_RD    = 8'h13;
    localparam logic [7:0]  CMD_DESCB_WR    = 8'h93;
    localparam int          BIT_POWER_OFF   = 0;
    localparam int          BIT_OC_FLAG     = 1;
    localparam int          BIT_WAKE_EN     = 15;
    localparam int          BIT_POWER_ON    = 16;
    localparam int          BIT_OC_CHANGE   = 17;
    localparam int          BIT_WAKE_CLR    = 31;
    localparam int          MASK_LSB        = 16;
    localparam int          MASK_FIELD_W    = 3;
    localparam logic [31:0] STATUS_RESET    = 32'h0000_0000;
    localparam logic        FLAG_RESET      = 1'b0;

    typedef struct packed {
        logic        valid;
        logic [7:0]  code;
        logic [31:0] data;
    } rhs_cmd_t;
endpackage
`default_nettype wire

/* File: bench/testbench.sv */
/*
 * testbench: self-checking bench for the root hub global status block.
 * Assumes rhs_pkg and rhs_root_hub_status are compiled first; NUM_PORTS is 2.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic [7:0]  code;
        logic [31:0] data;
        logic        oc;
        logic        ppoc;
        logic        ppsw;
        logic [31:0] exp_st;
        logic [1:0]  exp_pw;
    } rhs_row_t;

    logic              CLOCK = 1'h0;
    logic              RST_N = 1'h0;
    rhs_pkg::rhs_cmd_t cmd   = '0;
    logic              OC_IN = 1'h0;
    logic              PER_PORT_OC = 1'h0;
    logic              PER_PORT_SWITCH = 1'h0;
    logic [2:1]        ATTACH_CHANGE = 2'h0;
    logic              SUSPENDED = 1'h0;
    logic [31:0]       RD_DATA;
    logic              RD_VALID;
    logic [2:1]        PORT_POWERED;
    logic              RESUME_REQ;
    logic              RESUME_IRQ;
    logic [31:0]       val;
    int                fails = 0;
    int                checks_done = 0;
    rhs_row_t          rows [14];

    rhs_root_hub_status #(.NUM_PORTS(2)) dut_u (
        .CLOCK(CLOCK), .RST_N(RST_N), .CMD(cmd), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
        .OC_IN(OC_IN), .PER_PORT_OC(PER_PORT_OC), .PER_PORT_SWITCH(PER_PORT_SWITCH),
        .ATTACH_CHANGE(ATTACH_CHANGE), .SUSPENDED(SUSPENDED), .PORT_POWERED(PORT_POWERED),
        .RESUME_REQ(RESUME_REQ), .RESUME_IRQ(RESUME_IRQ));

    always #4 CLOCK = ~CLOCK;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic send(input logic [7:0] code, input logic [31:0] data);
        @(posedge CLOCK);
        cmd <= '{1'h1, code, data};
        @(posedge CLOCK);
        cmd <= '0;
    endtask

    // the read strobe stands for one cycle only, so sample right after the edge
    task automatic rd(input logic [7:0] code, output logic [31:0] v);
        send(code, 32'h0);
        #1;
        chk({31'h0, RD_VALID}, 32'h1);
        v = RD_DATA;
    endtask

    task automatic print_verdict();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        #100000;
        fails++;
        print_verdict();
    end

    initial
    begin
        rows[0]  = '{8'h94, 32'h0000_8000, 1'h0, 1'h0, 1'h0, 32'h0000_8000, 2'h0};
        rows[1]  = '{8'h94, 32'h0001_0000, 1'h0, 1'h0, 1'h0, 32'h0000_8000, 2'h3};
        rows[2]  = '{8'h94, 32'h0000_0001, 1'h0, 1'h0, 1'h0, 32'h0000_8000, 2'h0};
        rows[3]  = '{8'h94, 32'h8000_0000, 1'h0, 1'h0, 1'h0, 32'h0000_0000, 2'h0};
        rows[4]  = '{8'h94, 32'h0000_0000, 1'h1, 1'h0, 1'h0, 32'h0002_0002, 2'h0};
        rows[5]  = '{8'h94, 32'h0002_0000, 1'h1, 1'h0, 1'h0, 32'h0000_0002, 2'h0};
        rows[6]  = '{8'h94, 32'h0000_0000, 1'h0, 1'h0, 1'h0, 32'h0002_0000, 2'h0};
        rows[7]  = '{8'h94, 32'h0002_0000, 1'h1, 1'h1, 1'h0, 32'h0000_0000, 2'h0};
        rows[8]  = '{8'h93, 32'h0004_0000, 1'h0, 1'h0, 1'h0, 32'h0000_0000, 2'h0};
        rows[9]  = '{8'h94, 32'h0001_0000, 1'h0, 1'h0, 1'h1, 32'h0000_0000, 2'h1};
        rows[10] = '{8'h94, 32'h0001_0000, 1'h0, 1'h0, 1'h0, 32'h0000_0000, 2'h3};
        rows[11] = '{8'h94, 32'h0000_0001, 1'h0, 1'h0, 1'h1, 32'h0000_0000, 2'h2};
        // set and clear of wake-up together: clear wins; power on and off together: on wins
        rows[12] = '{8'h94, 32'h8000_8000, 1'h0, 1'h0, 1'h0, 32'h0000_0000, 2'h2};
        rows[13] = '{8'h94, 32'h0001_0001, 1'h0, 1'h0, 1'h0, 32'h0000_0000, 2'h3};
        repeat (8) @(posedge CLOCK);
        RST_N <= 1'h1;
        rd(8'h14, val);
        chk(val, 32'h0);
        chk({30'h0, PORT_POWERED}, 32'h0);
        foreach (rows[i])
        begin
            @(posedge CLOCK);
            OC_IN <= rows[i].oc;
            PER_PORT_OC <= rows[i].ppoc;
            PER_PORT_SWITCH <= rows[i].ppsw;
            send(rows[i].code, rows[i].data);
            rd(8'h14, val);
            chk(val, rows[i].exp_st);
            chk({30'h0, PORT_POWERED}, {30'h0, rows[i].exp_pw});
        end
        rd(8'h13, val);
        chk(val, 32'h0004_0000);
        send(8'h55, 32'h0);
        #1;
        chk({31'h0, RD_VALID}, 32'h0);
        // overcurrent edge lands in the same cycle as the clear of its change flag
        @(posedge CLOCK);
        OC_IN <= 1'h1;
        repeat (2) @(posedge CLOCK);
        cmd <= '{1'h1, 8'h94, 32'h0002_0000};
        OC_IN <= 1'h0;
        @(posedge CLOCK);
        cmd <= '0;
        rd(8'h14, val);
        chk(val, 32'h0002_0000);
        send(8'h94, 32'h0000_8000);
        // pass 0 is awake, pass 1 suspended with wake-up on, pass 2 with wake-up cleared
        for (int k = 0; k < 3; k++)
        begin
            @(posedge CLOCK);
            SUSPENDED <= (k != 0);
            ATTACH_CHANGE <= 2'h2;
            @(posedge CLOCK);
            ATTACH_CHANGE <= 2'h0;
            #1;
            chk({30'h0, RESUME_REQ, RESUME_IRQ}, (k == 1) ? 32'h3 : 32'h0);
            @(posedge CLOCK);
            #1;
            chk({30'h0, RESUME_REQ, RESUME_IRQ}, 32'h0);
            if (k == 1)
                send(8'h94, 32'h8000_0000);
        end
        @(posedge CLOCK);
        RST_N <= 1'h0;
        #1;
        chk({30'h0, PORT_POWERED}, 32'h0);
        @(posedge CLOCK);
        RST_N <= 1'h1;
        rd(8'h14, val);
        chk(val, 32'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
